// ===== qmd_regs.svh
// Register offsets, field positions and reset values of the quadrature motion decoder.
`ifndef QMD_REGS_SVH
`define QMD_REGS_SVH
// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define QMD_OFF_CTRL      8'h00
`define QMD_OFF_PERIOD    8'h04
`define QMD_OFF_SAMPLE    8'h08
`define QMD_OFF_ACC       8'h0C
`define QMD_OFF_DBL       8'h10
`define QMD_OFF_STATUS    8'h14
`define QMD_OFF_MASK      8'h18
`define QMD_OFF_STATE     8'h1C
// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define QMD_CTRL_START    0
`define QMD_CTRL_STOP     1
`define QMD_CTRL_CLEAR    2
`define QMD_EV_READY      0
`define QMD_EV_STOPPED    1
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define QMD_RST_PERIOD    16'h0007
`define QMD_RST_MASK      2'h0
`endif

// ===== qmd_pkg.sv
// Types shared by the quadrature motion decoder files.
package qmd_pkg;
   localparam int ACC_W = 32;
   typedef enum logic [1:0] {QMD_IDLE, QMD_PRIME, QMD_RUN} qmd_state_t;
   typedef struct packed {
      logic       a;
      logic       b;
   } qmd_pair_t;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } qmd_bus_t;
   typedef struct packed {
      qmd_state_t        state;
      qmd_pair_t         prev;
      logic [2:0]        sample;
      logic [ACC_W-1:0]  acc;
      logic [ACC_W-1:0]  dbl;
      logic [15:0]       period;
      logic [1:0]        status;
      logic [1:0]        mask;
      logic [31:0]       rdata;
   } qmd_regs_t;
endpackage

// ===== qmd_period_timer.sv
// Sample-interval timer of the quadrature motion decoder.
`timescale 1ns/1ps
`default_nettype none
module qmd_period_timer #(
   parameter int PERIOD_W = 16
) (
   input  wire logic                sys_clk_i,
   input  wire logic                rstn_i,
   input  wire logic                run_i,
   input  wire logic [PERIOD_W-1:0] period_i,
   output logic                     tick_o
);
   logic [PERIOD_W-1:0] cnt_q;
   logic [PERIOD_W-1:0] cnt_d;

   // The interval is period_i plus one cycles, so a zero period still advances.
   always_comb begin
      cnt_d = cnt_q + {{(PERIOD_W-1){1'b0}}, 1'b1};
      if (!run_i || cnt_q >= period_i) begin
         cnt_d = '0;
      end
   end

   assign tick_o = run_i && (cnt_q >= period_i);

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

// ===== qmd_core.sv
// Quadrature motion decoder core with register port and interrupt.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "qmd_regs.svh"
module qmd_core (
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        phase_a_i,
   input  wire logic        phase_b_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [31:0]      rdata_o,
   output logic             irq_o,
   output logic             running_o
);
   qmd_pkg::qmd_regs_t r_q;
   qmd_pkg::qmd_regs_t r_d;
   qmd_pkg::qmd_bus_t  bus;
   qmd_pkg::qmd_pair_t cur;
   logic               tick;
   logic               timer_run;
   logic               start_req;
   logic               stop_req;
   logic               clr_req;
   logic               both_chg;
   logic               any_chg;
   logic               step_up;
   logic [1:0]         ev_set;
   logic [1:0]         ev_clr;

   // ----------------------------------------------------------------------
   // Sample timer
   // ----------------------------------------------------------------------
   assign timer_run = (r_q.state != qmd_pkg::QMD_IDLE);

   qmd_period_timer #(
      .PERIOD_W (16)
   ) u_timer (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .run_i     (timer_run),
      .period_i  (r_q.period),
      .tick_o    (tick)
   );

   // ----------------------------------------------------------------------
   // Decode and registers
   // ----------------------------------------------------------------------
   assign bus       = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
   assign cur       = '{a: phase_a_i, b: phase_b_i};
   assign start_req = bus.wr && bus.addr == `QMD_OFF_CTRL && bus.wdata[`QMD_CTRL_START];
   assign stop_req  = bus.wr && bus.addr == `QMD_OFF_CTRL && bus.wdata[`QMD_CTRL_STOP];
   assign clr_req   = bus.wr && bus.addr == `QMD_OFF_CTRL && bus.wdata[`QMD_CTRL_CLEAR];
   assign any_chg   = (cur != r_q.prev);
   assign both_chg  = (cur.a != r_q.prev.a) && (cur.b != r_q.prev.b);
   // Forward steps are exactly those where the new A equals the old B.
   assign step_up   = (cur.a == r_q.prev.b);

   always_comb begin
      r_d    = r_q;
      ev_set = 2'h0;
      ev_clr = 2'h0;
      r_d.rdata = 32'h0000_0000;
      case (r_q.state)
         qmd_pkg::QMD_IDLE: begin
            if (start_req && !stop_req) begin
               r_d.state = qmd_pkg::QMD_PRIME;
            end
         end
         qmd_pkg::QMD_PRIME: begin
            if (tick) begin
               r_d.prev  = cur;
               r_d.state = qmd_pkg::QMD_RUN;
            end
         end
         qmd_pkg::QMD_RUN: begin
            if (tick) begin
               r_d.prev = cur;
               ev_set[`QMD_EV_READY] = 1'b1;
               if (!any_chg) begin
                  r_d.sample = 3'h0;
               end else if (both_chg) begin
                  r_d.sample = 3'h2;
                  r_d.dbl    = r_q.dbl + 1'b1;
               end else if (step_up) begin
                  r_d.sample = 3'h1;
                  r_d.acc    = r_q.acc + 1'b1;
               end else begin
                  r_d.sample = 3'h7;
                  r_d.acc    = r_q.acc - 1'b1;
               end
            end
         end
         default: begin
            r_d.state = qmd_pkg::QMD_IDLE;
         end
      endcase
      if (stop_req) begin
         r_d.state = qmd_pkg::QMD_IDLE;
         ev_set[`QMD_EV_STOPPED] = 1'b1;
      end
      if (clr_req) begin
         r_d.acc = '0;
         r_d.dbl = '0;
      end
      if (bus.wr && bus.addr == `QMD_OFF_PERIOD) begin
         r_d.period = bus.wdata[15:0];
      end else if (bus.wr && bus.addr == `QMD_OFF_MASK) begin
         r_d.mask = bus.wdata[1:0];
      end
      if (bus.rd) begin
         if (bus.addr == `QMD_OFF_PERIOD) begin
            r_d.rdata = {16'h0000, r_q.period};
         end else if (bus.addr == `QMD_OFF_SAMPLE) begin
            r_d.rdata = {{29{r_q.sample[2]}}, r_q.sample};
         end else if (bus.addr == `QMD_OFF_ACC) begin
            r_d.rdata = r_q.acc;
         end else if (bus.addr == `QMD_OFF_DBL) begin
            r_d.rdata = r_q.dbl;
         end else if (bus.addr == `QMD_OFF_STATUS) begin
            r_d.rdata = {30'h0000_0000, r_q.status};
            ev_clr    = 2'h3;
         end else if (bus.addr == `QMD_OFF_MASK) begin
            r_d.rdata = {30'h0000_0000, r_q.mask};
         end else if (bus.addr == `QMD_OFF_STATE) begin
            r_d.rdata = {30'h0000_0000, r_q.state};
         end else begin
            r_d.rdata = 32'h0000_0000;
         end
      end
      // A new event beats the clear of a status read in the same cycle.
      r_d.status = (r_q.status & ~ev_clr) | ev_set;
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r_q        <= '0;
         r_q.state  <= qmd_pkg::QMD_IDLE;
         r_q.period <= `QMD_RST_PERIOD;
         r_q.mask   <= `QMD_RST_MASK;
      end else begin
         r_q <= r_d;
      end
   end

   assign rdata_o   = r_q.rdata;
   assign irq_o     = |(r_q.status & r_q.mask);
   assign running_o = (r_q.state == qmd_pkg::QMD_RUN);

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);

   // Cycles since the last tick, so the interval can be held against the period.
   logic [16:0] gap_q;
   logic        seen_q;
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gap_q  <= 17'h0_0000;
         seen_q <= 1'b0;
      end else if (!timer_run || tick) begin
         gap_q  <= 17'h0_0001;
         seen_q <= timer_run;
      end else begin
         gap_q  <= gap_q + 17'h0_0001;
      end
   end

   sequence run_tick_s;
      (r_q.state == qmd_pkg::QMD_RUN) && tick && !stop_req && !clr_req;
   endsequence

   sequence prime_tick_s;
      (r_q.state == qmd_pkg::QMD_PRIME) && tick && !stop_req && !clr_req;
   endsequence

   sequence halted_s;
      (r_q.state == qmd_pkg::QMD_IDLE) && r_q.status[`QMD_EV_STOPPED] && !tick;
   endsequence

   tick_spacing_a: assert property (tick && seen_q && $stable(r_q.period) && timer_run
      |-> gap_q == {1'b0, r_q.period} + 17'h0_0001)
      else $error("sample interval differs from the period");
   idle_hold_a: assert property ((r_q.state == qmd_pkg::QMD_IDLE) && !clr_req
      |=> $stable(r_q.acc) && $stable(r_q.dbl))
      else $error("counts moved while stopped");
   no_move_a: assert property (run_tick_s and !any_chg
      |=> r_q.sample == 3'h0 && $stable(r_q.acc) && $stable(r_q.dbl))
      else $error("still pair did not report zero");
   step_up_a: assert property (run_tick_s and (any_chg && !both_chg && step_up)
      |=> r_q.sample == 3'h1 && r_q.acc == $past(r_q.acc) + 1'b1)
      else $error("forward step not counted up");
   step_down_a: assert property (run_tick_s and (any_chg && !both_chg && !step_up)
      |=> r_q.sample == 3'h7 && r_q.acc == $past(r_q.acc) - 1'b1)
      else $error("reverse step not counted down");
   double_step_a: assert property (run_tick_s and both_chg
      |=> r_q.sample == 3'h2 && $stable(r_q.acc) && r_q.dbl == $past(r_q.dbl) + 1'b1)
      else $error("double transition mishandled");
   ready_event_a: assert property (run_tick_s |=> r_q.status[`QMD_EV_READY])
      else $error("sample ready event missing");
   // A restart right after a stop may tick at once, so only a direct return to run is wrong.
   stop_event_a: assert property (stop_req
      |=> halted_s ##1 r_q.state != qmd_pkg::QMD_RUN)
      else $error("stop did not halt and signal");
   prime_first_a: assert property (prime_tick_s
      |=> r_q.state == qmd_pkg::QMD_RUN && $stable(r_q.sample) && $stable(r_q.dbl)
          && (!r_q.status[`QMD_EV_READY] || $past(r_q.status[`QMD_EV_READY])))
      else $error("first pair after start was decoded");
   start_prime_a: assert property (start_req && !stop_req
      && (r_q.state == qmd_pkg::QMD_IDLE) |=> r_q.state == qmd_pkg::QMD_PRIME)
      else $error("start did not prime the decoder");
   // A status read clears the flags only when no event arrives in the same cycle.
   status_clear_a: assert property (bus.rd && bus.addr == `QMD_OFF_STATUS && ev_set == 2'h0
      |=> r_q.status == 2'h0)
      else $error("status read did not clear");
   read_once_a: assert property (!bus.rd |=> rdata_o == 32'h0000_0000)
      else $error("read data outlived its cycle");
   acc_read_a: assert property (bus.rd && bus.addr == `QMD_OFF_ACC |=> rdata_o == $past(r_q.acc))
      else $error("accumulator read returned a wrong value");
   dbl_read_a: assert property (bus.rd && bus.addr == `QMD_OFF_DBL |=> rdata_o == $past(r_q.dbl))
      else $error("double count read returned a wrong value");
endmodule
`default_nettype wire

// ===== qmd_encoder_model.sv
// Behavioural model of the off-chip quadrature encoder.
`timescale 1ns/1ps
`default_nettype none
module qmd_encoder_model #(
   parameter int LAG = 2
) (
   input  wire logic               sys_clk_i,
   input  wire qmd_pkg::qmd_pair_t pos_i,
   output logic                    phase_a_o,
   output logic                    phase_b_o
);
   qmd_pkg::qmd_pair_t pipe_q [LAG];
   // A slow wheel shows a new position only LAG clocks later.
   always_ff @(posedge sys_clk_i) begin
      pipe_q[0] <= pos_i;
      for (int i = 1; i < LAG; i++) begin
         pipe_q[i] <= pipe_q[i-1];
      end
   end
   assign phase_a_o = pipe_q[LAG-1].a;
   assign phase_b_o = pipe_q[LAG-1].b;
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench of the quadrature motion decoder core.
`timescale 1ns/1ps
`default_nettype none
`include "qmd_regs.svh"
module tb_top;
   logic               sys_clk = 1'b0;
   logic               rst_n   = 1'b0;
   logic               wr      = 1'b0;
   logic               rd      = 1'b0;
   logic [7:0]         addr    = 8'h00;
   logic [31:0]        wdata   = 32'h0000_0000;
   logic [31:0]        rdata, d, e_acc, e_dbl;
   logic               pa, pb, irq, run;
   qmd_pkg::qmd_pair_t pos, last;
   logic [6:0]         rows [16];
   int                 err_total, checks_done, cyc, n;
   localparam logic [2:0] CODE [16] = '{3'h0, 3'h1, 3'h7, 3'h2, 3'h7, 3'h0, 3'h2, 3'h1,
                                        3'h1, 3'h2, 3'h0, 3'h7, 3'h2, 3'h7, 3'h1, 3'h0};
   qmd_core DUT (
      .sys_clk_i (sys_clk),
      .rstn_i    (rst_n),
      .phase_a_i (pa),
      .phase_b_i (pb),
      .addr_i    (addr),
      .wdata_i   (wdata),
      .wr_i      (wr),
      .rd_i      (rd),
      .rdata_o   (rdata),
      .irq_o     (irq),
      .running_o (run)
   );
   qmd_encoder_model #(.LAG(2)) enc (
      .sys_clk_i (sys_clk),
      .pos_i     (pos),
      .phase_a_o (pa),
      .phase_b_o (pb)
   );
   always #20 sys_clk = ~sys_clk;
   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a);
      @(posedge sys_clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(negedge sys_clk);
      d = rdata;
   endtask
   task automatic wait_lvl(ref logic s, input logic v);
      n = 0;
      @(negedge sys_clk);
      while (s !== v && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 100) err_total++;
   endtask
   // Syncs to a tick, then moves the wheel and checks the next decode.
   task automatic step(input qmd_pkg::qmd_pair_t nw);
      logic [2:0] code;
      code = rows[{last, nw}][2:0];
      wait_lvl(irq, 1'b1);
      rreg(`QMD_OFF_STATUS);
      @(posedge sys_clk);
      pos <= nw;
      if (code == 3'h1) e_acc = e_acc + 32'h0000_0001;
      if (code == 3'h7) e_acc = e_acc - 32'h0000_0001;
      if (code == 3'h2) e_dbl = e_dbl + 32'h0000_0001;
      wait_lvl(irq, 1'b1);
      check(n, 13);
      rreg(`QMD_OFF_STATUS);
      check(d & 32'h0000_0001, 32'h0000_0001);
      rreg(`QMD_OFF_SAMPLE);
      check(d, {{29{code[2]}}, code});
      rreg(`QMD_OFF_ACC);
      check(d, e_acc);
      rreg(`QMD_OFF_DBL);
      check(d, e_dbl);
      last = nw;
   endtask
   // ----------------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------------
   initial begin
      err_total = 0;
      checks_done = 0;
      pos = 2'b11;
      last = 2'b11;
      e_acc = 32'h0000_0000;
      e_dbl = 32'h0000_0000;
      for (int i = 0; i < 16; i++) begin
         rows[i] = {4'(i), CODE[i]};
      end
      repeat (4) @(posedge sys_clk);
      check({rdata[31:2], irq, run}, 32'h0000_0000);
      rst_n <= 1'b1;
      rreg(`QMD_OFF_PERIOD);
      check(d, 32'h0000_0007);
      rreg(`QMD_OFF_MASK);
      check(d, 32'h0000_0000);
      rreg(8'h20);
      check(d, 32'h0000_0000);
      wreg(`QMD_OFF_ACC, 32'h0000_0005);
      rreg(`QMD_OFF_ACC);
      check(d, 32'h0000_0000);
      wreg(`QMD_OFF_PERIOD, 32'h0000_000F);
      rreg(`QMD_OFF_PERIOD);
      check(d, 32'h0000_000F);
      wreg(`QMD_OFF_CTRL, 32'h0000_0001);
      wait_lvl(run, 1'b1);
      repeat (40) @(negedge sys_clk);
      check({31'h0, irq}, 32'h0000_0000);
      wreg(`QMD_OFF_MASK, 32'h0000_0001);
      @(negedge sys_clk);
      check({31'h0, irq}, 32'h0000_0001);
      rreg(`QMD_OFF_STATUS);
      // The wheel sat at 11 since reset, so a primed start sees no double step.
      step(2'b11);
      for (int i = 0; i < 16; i++) begin
         step(rows[i][6:5]);
         step(rows[i][4:3]);
      end
      wreg(`QMD_OFF_CTRL, 32'h0000_0002);
      wait_lvl(run, 1'b0);
      rreg(`QMD_OFF_STATUS);
      check(d & 32'h0000_0002, 32'h0000_0002);
      @(posedge sys_clk);
      pos <= 2'b00;
      repeat (40) @(posedge sys_clk);
      rreg(`QMD_OFF_ACC);
      check(d, e_acc);
      wreg(`QMD_OFF_CTRL, 32'h0000_0004);
      rreg(`QMD_OFF_ACC);
      check(d, 32'h0000_0000);
      rreg(`QMD_OFF_DBL);
      check(d, 32'h0000_0000);
      wreg(`QMD_OFF_CTRL, 32'h0000_0003);
      repeat (40) @(negedge sys_clk);
      check({31'h0, run}, 32'h0000_0000);
      // The stop above raised stopped although the decoder was idle already.
      wreg(`QMD_OFF_MASK, 32'h0000_0002);
      @(negedge sys_clk);
      check({31'h0, irq}, 32'h0000_0001);
      rreg(`QMD_OFF_STATUS);
      check(d, 32'h0000_0002);
      @(negedge sys_clk);
      check(rdata, 32'h0000_0000);
      check({31'h0, irq}, 32'h0000_0000);
      wreg(`QMD_OFF_CTRL, 32'h0000_0001);
      rreg(`QMD_OFF_STATE);
      check(d, 32'h0000_0001);
      wait_lvl(run, 1'b1);
      rreg(`QMD_OFF_STATE);
      check(d, 32'h0000_0002);
      // A reset in mid-run must drop the run and bring back the reset settings.
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check({rdata[31:2], irq, run}, 32'h0000_0000);
      rst_n <= 1'b1;
      rreg(`QMD_OFF_PERIOD);
      check(d, 32'h0000_0007);
      rreg(`QMD_OFF_STATE);
      check(d, 32'h0000_0000);
      rreg(`QMD_OFF_MASK);
      check(d, 32'h0000_0000);
      give_verdict();
   end
endmodule
`default_nettype wire
